/* verilog/sbcwd_cfg.svh */
// Constants for the windowed watchdog: offsets, fields, codes and timing.
`ifndef SBCWD_CFG_SVH
`define SBCWD_CFG_SVH

`define SBCWD_ADDR_CTRL 7'h00
`define SBCWD_ADDR_STAT 7'h05
`define SBCWD_ADDR_CFG 7'h74

`define SBCWD_MODE_AUTO 3'h1
`define SBCWD_MODE_TMO 3'h2
`define SBCWD_MODE_WIN 3'h4

`define SBCWD_PER_8 4'h8
`define SBCWD_PER_16 4'h1
`define SBCWD_PER_32 4'h2
`define SBCWD_PER_64 4'hb
`define SBCWD_PER_128 4'h4
`define SBCWD_PER_256 4'hd
`define SBCWD_PER_1024 4'he
`define SBCWD_PER_4096 4'h7
`define SBCWD_PER_DEFAULT `SBCWD_PER_128

`define SBCWD_PHASE_OFF 2'h0
`define SBCWD_PHASE_FIRST 2'h1
`define SBCWD_PHASE_SECOND 2'h2

`define SBCWD_CFG_FNM_BIT 3
`define SBCWD_CFG_SDM_BIT 2
`define SBCWD_CFG_AUX_BIT 1
`define SBCWD_CFG_SLP_BIT 0
`define SBCWD_CFG_RESET 8'h08

`define SBCWD_RSS_EARLY 5'h0e
`define SBCWD_RSS_OVF 5'h0f
`define SBCWD_RSS_ILLEGAL 5'h10

`define SBCWD_FRAME_BITS 16
`define SBCWD_CLK_NS 5
`define SBCWD_TICK_NS 1000000
`define SBCWD_TICK_CYCLES (`SBCWD_TICK_NS / `SBCWD_CLK_NS)

`endif

/* verilog/sbcwd_pkg.sv */
// Types shared by the windowed watchdog design.
package sbcwd_pkg;

    typedef enum logic [2:0] {
        SBCWD_SBC_NORMAL = 3'h0,
        SBCWD_SBC_STANDBY = 3'h1,
        SBCWD_SBC_SLEEP = 3'h2,
        SBCWD_SBC_FORCED = 3'h3,
        SBCWD_SBC_RESET = 3'h4,
        SBCWD_SBC_OTHER = 3'h5
    } sbcwd_sbc_mode_t;

    typedef enum logic [1:0] {
        SBCWD_BEH_OFF = 2'h0,
        SBCWD_BEH_TIMEOUT = 2'h1,
        SBCWD_BEH_WINDOW = 2'h3
    } sbcwd_beh_t;

    typedef struct packed {
        logic [1:0] startup_uv_threshold;
        logic forced_norm_cfg;
        logic sw_dev_cfg;
        logic aux_supply_arrangement;
        logic sleep_support_cfg;
    } sbcwd_nvcfg_t;

    typedef struct packed {
        logic sys_reset_req;
        logic [4:0] reset_source_code;
    } sbcwd_reset_t;

endpackage

/* verilog/sbcwd_sync.sv */
// Three-stage input synchroniser; a change counts once stages two and three agree.
`timescale 1ns/1ps
module sbcwd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Asynchronous input and qualified level.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Each bit is held until the last two stages see the same value.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= INIT;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

/* verilog/sbcwd_top.sv */
// Windowed watchdog supervisor with its serial register port.
//
// Summary of operation
// - Software-development mode reloads autonomous selection after reset.
// - Autonomous plus software-development keeps watchdog off.
// - Window behaviour only with window code in Normal.
// - Window: overflow or early trigger requests reset.
// - Window: trigger in second half restarts timer.
// - Timeout behaviour for timeout or deferred window code.
// - Timeout: overflow sets the watchdog interrupt flag.
// - Timeout: overflow with flag pending requests reset.
// - Overflow in Sleep produces a wake-up event.
// - Autonomous: timeout in Normal, Standby with interrupt low.
// - Control write restarts period, phase reads first half.
// - Phase status: off, first half, second half.
// - Status bits report forced-normal and software-development.
// - Start-up threshold field selects ninety to sixty percent.
// - Configuration bit three enables forced-normal, preset set.
// - Configuration bit two enables software-development, preset clear.
// - Configuration bit zero marks Sleep unsupported when set.
// - Configuration bit one selects secondary regulator arrangement.
// - Eight periods 8 to 4096 ms, default 128.
// - Any valid control write is a trigger, immediate, except a mode change in Normal.
// - Mode change in Normal forces reset, illegal-access code.
// - Forced-normal operation disables the watchdog.
`timescale 1ns/1ps
`include "sbcwd_cfg.svh"
module sbcwd_top #(
    parameter int TICK_CYCLES = `SBCWD_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Serial register port from the host.
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic spi_fail,
    // Chip state.
    input wire sbcwd_pkg::sbcwd_sbc_mode_t sbc_mode,
    input wire logic irq_out_n,
    input wire logic wd_flag_clear,
    // Watchdog results.
    output logic wd_overflow_flag,
    output logic wake_event,
    output sbcwd_pkg::sbcwd_reset_t reset_out,
    output logic [1:0] wd_phase_status,
    // Configuration outputs.
    output sbcwd_pkg::sbcwd_nvcfg_t nvcfg,
    output logic forced_norm_active,
    output logic sw_dev_active
);
    logic sck_q;
    logic cs_n_q;
    logic mosi_q;
    logic sck_prev_reg;
    logic sck_rise;
    logic sck_fall;
    logic [4:0] bit_cnt_reg;
    logic [15:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] rd_data;
    logic frame_end;
    logic wr_valid;
    logic wr_ctrl;
    logic wr_cfg;
    logic bad_code;
    logic illegal_mode;
    logic [2:0] wd_mode_select;
    logic [3:0] wd_period_select;
    logic [12:0] period_ms;
    logic [12:0] trigger_time_first;
    logic [17:0] tick_cnt_reg;
    logic tick;
    logic [12:0] ms_cnt_reg;
    sbcwd_pkg::sbcwd_beh_t beh;
    logic trigger;
    logic overflow;
    logic early;
    logic [7:0] nv_raw;

    sbcwd_sync #(
        .W(3),
        .INIT(3'h2)
    ) u_sync (
        .clk(sys_clk),
        .rst(rst),
        .d({spi_sck, spi_cs_n, spi_mosi}),
        .q({sck_q, cs_n_q, mosi_q})
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_q;
        end
    end

    assign sck_rise = sck_q && !sck_prev_reg && !cs_n_q;
    assign sck_fall = !sck_q && sck_prev_reg && !cs_n_q;

    // Frames are address, read flag, data, most significant bit first.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
        end else if (cs_n_q) begin
            bit_cnt_reg <= 5'h00;
        end else if (sck_rise) begin
            shift_reg <= {shift_reg[14:0], mosi_q};
            if (bit_cnt_reg != 5'h1f) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // The address sits in the low seven bits while the read flag shifts in.
    always_comb begin
        case (shift_reg[6:0])
            `SBCWD_ADDR_CTRL: rd_data = {wd_mode_select, 1'b0,
                                         wd_period_select};
            `SBCWD_ADDR_STAT: rd_data = {4'h0, forced_norm_active,
                                         sw_dev_active,
                                         wd_phase_status};
            `SBCWD_ADDR_CFG: rd_data = nv_raw;
            default: rd_data = 8'h00;
        endcase
    end

    // Read data is loaded with the eighth bit and shifted on falling edges.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_reg <= 8'h00;
        end else if (cs_n_q) begin
            tx_reg <= 8'h00;
        end else if (sck_rise && bit_cnt_reg == 5'h07) begin
            tx_reg <= rd_data;
        end else if (sck_fall && bit_cnt_reg > 5'h08) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    assign spi_miso = tx_reg[7];
    assign spi_miso_oe = !cs_n_q;

    // A frame only counts when chip select rises after exactly 16 bits.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_end <= 1'b0;
        end else begin
            frame_end <= !cs_n_q;
        end
    end

    assign wr_valid = frame_end && cs_n_q
                      && bit_cnt_reg == 5'(`SBCWD_FRAME_BITS)
                      && !shift_reg[8];
    assign wr_ctrl = wr_valid && shift_reg[15:9] == `SBCWD_ADDR_CTRL;
    assign wr_cfg = wr_valid && shift_reg[15:9] == `SBCWD_ADDR_CFG;

    // Redundant codes: any other value abandons the write.
    always_comb begin
        bad_code = 1'b0;
        case (shift_reg[7:5])
            `SBCWD_MODE_AUTO, `SBCWD_MODE_TMO, `SBCWD_MODE_WIN: ;
            default: bad_code = 1'b1;
        endcase
        case (shift_reg[3:0])
            `SBCWD_PER_8, `SBCWD_PER_16, `SBCWD_PER_32, `SBCWD_PER_64,
            `SBCWD_PER_128, `SBCWD_PER_256, `SBCWD_PER_1024,
            `SBCWD_PER_4096: ;
            default: bad_code = 1'b1;
        endcase
    end

    assign spi_fail = wr_ctrl && bad_code;
    assign illegal_mode = wr_ctrl && !bad_code
                          && sbc_mode == sbcwd_pkg::SBCWD_SBC_NORMAL
                          && shift_reg[7:5] != wd_mode_select;
    assign trigger = wr_ctrl && !bad_code && !illegal_mode;

    // Nonvolatile configuration; forced-normal is preset enabled.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nv_raw <= `SBCWD_CFG_RESET;
        end else if (wr_cfg) begin
            nv_raw <= {2'h0, shift_reg[5:0]};
        end
    end

    assign nvcfg.startup_uv_threshold = nv_raw[5:4];
    assign nvcfg.forced_norm_cfg = nv_raw[`SBCWD_CFG_FNM_BIT];
    assign nvcfg.sw_dev_cfg = nv_raw[`SBCWD_CFG_SDM_BIT];
    assign nvcfg.aux_supply_arrangement = nv_raw[`SBCWD_CFG_AUX_BIT];
    assign nvcfg.sleep_support_cfg = nv_raw[`SBCWD_CFG_SLP_BIT];
    assign forced_norm_active = sbc_mode == sbcwd_pkg::SBCWD_SBC_FORCED;
    assign sw_dev_active = nvcfg.sw_dev_cfg;

    // Every pass through Reset reloads the default selection.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wd_mode_select <= `SBCWD_MODE_TMO;
            wd_period_select <= `SBCWD_PER_DEFAULT;
        end else if (sbc_mode == sbcwd_pkg::SBCWD_SBC_RESET) begin
            wd_mode_select <= nvcfg.sw_dev_cfg ? `SBCWD_MODE_AUTO
                                               : `SBCWD_MODE_TMO;
            wd_period_select <= `SBCWD_PER_DEFAULT;
        end else if (trigger) begin
            wd_mode_select <= shift_reg[7:5];
            wd_period_select <= shift_reg[3:0];
        end
    end

    always_comb begin
        case (wd_period_select)
            `SBCWD_PER_8: period_ms = 13'd8;
            `SBCWD_PER_16: period_ms = 13'd16;
            `SBCWD_PER_32: period_ms = 13'd32;
            `SBCWD_PER_64: period_ms = 13'd64;
            `SBCWD_PER_256: period_ms = 13'd256;
            `SBCWD_PER_1024: period_ms = 13'd1024;
            `SBCWD_PER_4096: period_ms = 13'd4096;
            default: period_ms = 13'd128;
        endcase
    end

    assign trigger_time_first = {1'b0, period_ms[12:1]};

    // Selected mode and chip state give the running behaviour.
    always_comb begin
        beh = sbcwd_pkg::SBCWD_BEH_OFF;
        case (sbc_mode)
            sbcwd_pkg::SBCWD_SBC_NORMAL: begin
                if (wd_mode_select == `SBCWD_MODE_WIN) begin
                    beh = sbcwd_pkg::SBCWD_BEH_WINDOW;
                end else if (wd_mode_select == `SBCWD_MODE_TMO) begin
                    beh = sbcwd_pkg::SBCWD_BEH_TIMEOUT;
                end else if (!nvcfg.sw_dev_cfg) begin
                    beh = sbcwd_pkg::SBCWD_BEH_TIMEOUT;
                end
            end
            sbcwd_pkg::SBCWD_SBC_STANDBY, sbcwd_pkg::SBCWD_SBC_SLEEP: begin
                if (wd_mode_select != `SBCWD_MODE_AUTO) begin
                    beh = sbcwd_pkg::SBCWD_BEH_TIMEOUT;
                end else if (!nvcfg.sw_dev_cfg && !irq_out_n
                             && sbc_mode == sbcwd_pkg::SBCWD_SBC_STANDBY)
                begin
                    beh = sbcwd_pkg::SBCWD_BEH_TIMEOUT;
                end
            end
            sbcwd_pkg::SBCWD_SBC_FORCED: beh = sbcwd_pkg::SBCWD_BEH_OFF;
            default: beh = sbcwd_pkg::SBCWD_BEH_OFF;
        endcase
    end

    // Millisecond tick from the system clock.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 18'h00000;
        end else if (trigger || beh == sbcwd_pkg::SBCWD_BEH_OFF
                     || tick) begin
            tick_cnt_reg <= 18'h00000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 18'h00001;
        end
    end

    assign tick = tick_cnt_reg == 18'(TICK_CYCLES - 1);
    assign overflow = tick && ms_cnt_reg + 13'd1 >= period_ms;
    assign early = trigger && beh == sbcwd_pkg::SBCWD_BEH_WINDOW
                   && ms_cnt_reg < trigger_time_first;

    // Trigger wins over a coinciding overflow, so no spurious flag is raised.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ms_cnt_reg <= 13'h0000;
        end else if (trigger || beh == sbcwd_pkg::SBCWD_BEH_OFF) begin
            ms_cnt_reg <= 13'h0000;
        end else if (overflow) begin
            ms_cnt_reg <= 13'h0000;
        end else if (tick) begin
            ms_cnt_reg <= ms_cnt_reg + 13'd1;
        end
    end

    always_comb begin
        if (beh == sbcwd_pkg::SBCWD_BEH_OFF) begin
            wd_phase_status = `SBCWD_PHASE_OFF;
        end else if (ms_cnt_reg < trigger_time_first) begin
            wd_phase_status = `SBCWD_PHASE_FIRST;
        end else begin
            wd_phase_status = `SBCWD_PHASE_SECOND;
        end
    end

    // The flag's set wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wd_overflow_flag <= 1'b0;
        end else if (overflow && !trigger
                     && beh == sbcwd_pkg::SBCWD_BEH_TIMEOUT) begin
            wd_overflow_flag <= 1'b1;
        end else if (wd_flag_clear) begin
            wd_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_event <= 1'b0;
        end else begin
            wake_event <= overflow && !trigger
                          && beh == sbcwd_pkg::SBCWD_BEH_TIMEOUT
                          && sbc_mode == sbcwd_pkg::SBCWD_SBC_SLEEP;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reset_out.sys_reset_req <= 1'b0;
        end else begin
            reset_out.sys_reset_req <= illegal_mode || early
                || (overflow && !trigger && beh == sbcwd_pkg::SBCWD_BEH_WINDOW)
                || (overflow && !trigger && wd_overflow_flag
                    && beh == sbcwd_pkg::SBCWD_BEH_TIMEOUT);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reset_out.reset_source_code <= 5'h00;
        end else if (illegal_mode) begin
            reset_out.reset_source_code <= `SBCWD_RSS_ILLEGAL;
        end else if (early) begin
            reset_out.reset_source_code <= `SBCWD_RSS_EARLY;
        end else if (overflow && !trigger && (wd_overflow_flag
                     || beh == sbcwd_pkg::SBCWD_BEH_WINDOW)
                     && beh != sbcwd_pkg::SBCWD_BEH_OFF) begin
            reset_out.reset_source_code <= `SBCWD_RSS_OVF;
        end
    end
endmodule

/* test/sbcwd_chk.sv */
// Port-level assertion checker for the windowed watchdog.
`timescale 1ns/1ps
`include "sbcwd_cfg.svh"
module sbcwd_chk #(
    parameter int TICK_CYCLES = 10
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports.
    input wire sbcwd_pkg::sbcwd_sbc_mode_t sbc_mode,
    input wire logic wd_flag_clear,
    input wire logic wd_overflow_flag,
    input wire logic wake_event,
    input wire sbcwd_pkg::sbcwd_reset_t reset_out,
    input wire logic [1:0] wd_phase_status,
    input wire sbcwd_pkg::sbcwd_nvcfg_t nvcfg,
    input wire logic forced_norm_active,
    input wire logic sw_dev_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_PHASE_RSVD: assert property (wd_phase_status != 2'h3)
        else $error("phase status shows the reserved code");
    AST_FNM_ACT: assert property (forced_norm_active ==
        (sbc_mode == sbcwd_pkg::SBCWD_SBC_FORCED))
        else $error("forced-normal status does not follow the mode");
    AST_FNM_OFF: assert property (sbc_mode == sbcwd_pkg::SBCWD_SBC_FORCED
        && $past(sbc_mode) == sbcwd_pkg::SBCWD_SBC_FORCED
        |-> wd_phase_status == `SBCWD_PHASE_OFF)
        else $error("watchdog runs in forced normal");
    AST_OTHER_OFF: assert property ((sbc_mode == sbcwd_pkg::SBCWD_SBC_OTHER)
        [*2] |-> wd_phase_status == `SBCWD_PHASE_OFF && !wake_event)
        else $error("watchdog runs in another mode");
    AST_SDM_STAT: assert property ($stable(nvcfg.sw_dev_cfg) &&
        nvcfg.sw_dev_cfg == $past(nvcfg.sw_dev_cfg, 2)
        |-> sw_dev_active == nvcfg.sw_dev_cfg)
        else $error("development status does not follow its bit");
    AST_WAKE_MODE: assert property (wake_event |->
        $past(sbc_mode) == sbcwd_pkg::SBCWD_SBC_SLEEP)
        else $error("wake event outside sleep");
    AST_WAKE_PULSE: assert property (wake_event |=> !wake_event)
        else $error("wake event longer than one cycle");
    AST_RST_PULSE: assert property (reset_out.sys_reset_req |=>
        !reset_out.sys_reset_req)
        else $error("reset request longer than one cycle");
    AST_RST_CODE: assert property (reset_out.sys_reset_req |->
        reset_out.reset_source_code inside {`SBCWD_RSS_EARLY,
        `SBCWD_RSS_OVF, `SBCWD_RSS_ILLEGAL})
        else $error("reset request with a foreign source code");
    AST_FLAG_HOLD: assert property (wd_overflow_flag && !wd_flag_clear
        |=> wd_overflow_flag)
        else $error("overflow flag dropped without a clear");
endmodule
bind sbcwd_top sbcwd_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .sbc_mode(sbc_mode),
    .wd_flag_clear(wd_flag_clear), .wd_overflow_flag(wd_overflow_flag),
    .wake_event(wake_event), .reset_out(reset_out),
    .wd_phase_status(wd_phase_status), .nvcfg(nvcfg),
    .forced_norm_active(forced_norm_active), .sw_dev_active(sw_dev_active));

/* test/sbcwd_host.sv */
// Host model that writes and reads the watchdog registers serially.
`timescale 1ns/1ps
module sbcwd_host (
    // Serial lines.
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    logic last;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        last = 1'b0;
    end
    // The clock stands still between frames; a released line reads inverted.
    task automatic xfer(input logic [6:0] a, input logic rd,
        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        logic b;
        f = {a, rd, d};
        q = 8'h00;
        spi_cs_n = 1'b0;
        #62.5;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = f[i];
            #62.5;
            spi_sck = 1'b1;
            b = spi_miso_oe ? spi_miso : ~last;
            last = b;
            if (i < 8) q[i] = b;
            #62.5;
            spi_sck = 1'b0;
        end
        #62.5;
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        // The gap keeps frames far enough apart for the synchroniser.
        #150;
    endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the windowed watchdog.
`timescale 1ns/1ps
`include "sbcwd_cfg.svh"
module tb;
    logic sys_clk, rst, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic spi_fail, irq_out_n, wd_flag_clear, wd_overflow_flag, wake_event;
    logic forced_norm_active, sw_dev_active;
    logic [1:0] wd_phase_status;
    logic [7:0] rd;
    sbcwd_pkg::sbcwd_sbc_mode_t sbc_mode;
    sbcwd_pkg::sbcwd_reset_t reset_out;
    sbcwd_pkg::sbcwd_nvcfg_t nvcfg;
    int n_mismatch, tests_run, n_rst, n_wake, n_fail;
    sbcwd_top #(.TICK_CYCLES(200)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .spi_fail(spi_fail), .sbc_mode(sbc_mode), .irq_out_n(irq_out_n),
        .wd_flag_clear(wd_flag_clear), .wd_overflow_flag(wd_overflow_flag),
        .wake_event(wake_event), .reset_out(reset_out),
        .wd_phase_status(wd_phase_status), .nvcfg(nvcfg),
        .forced_norm_active(forced_norm_active),
        .sw_dev_active(sw_dev_active));
    sbcwd_host u_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // One-cycle pulses are counted so that none is missed between checks.
    always @(posedge sys_clk) begin
        if (reset_out.sys_reset_req === 1'b1) n_rst++;
        if (wake_event === 1'b1) n_wake++;
        if (spi_fail === 1'b1) n_fail++;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.xfer(a, 1'b0, d, rd);
        @(negedge sys_clk);
    endtask
    task automatic rdck(input logic [6:0] a, input logic [7:0] exp);
        u_host.xfer(a, 1'b1, 8'h00, rd);
        @(negedge sys_clk);
        check(rd, exp);
    endtask
    task automatic wait_ev(input int w, input int n);
        for (int k = 0; k < n; k++) begin
            if (w == 0 && wd_phase_status === 2'h2) break;
            if (w == 1 && wd_overflow_flag === 1'b1) break;
            if (w == 2 && n_rst > 0) break;
            if (w == 3 && n_wake > 0) break;
            @(negedge sys_clk);
        end
    endtask
    task automatic t_reset();
        check(8'(nvcfg), 8'h08);
        rdck(`SBCWD_ADDR_CFG, `SBCWD_CFG_RESET);
        rdck(`SBCWD_ADDR_CTRL, 8'h44);
        rdck(`SBCWD_ADDR_STAT, 8'h01);
    endtask
    task automatic t_cfg();
        for (int t = 0; t < 4; t++) begin
            wr(`SBCWD_ADDR_CFG, {2'h0, 2'(t), 4'h3});
            check(8'(nvcfg), {2'h0, 2'(t), 4'h3});
            rdck(`SBCWD_ADDR_CFG, {2'h0, 2'(t), 4'h3});
        end
        wr(`SBCWD_ADDR_STAT, 8'hff);
        wr(7'h10, 8'h00);
        rdck(`SBCWD_ADDR_CFG, 8'h33);
        wr(`SBCWD_ADDR_CFG, 8'h00);
    endtask
    task automatic t_timeout();
        n_rst = 0;
        wr(`SBCWD_ADDR_CTRL, 8'h48);
        wr(`SBCWD_ADDR_CTRL, 8'h48);
        wd_flag_clear = 1'b1;
        @(negedge sys_clk);
        wd_flag_clear = 1'b0;
        check(8'(wd_phase_status), 8'h01);
        wait_ev(0, 1000);
        check(8'(wd_phase_status), 8'h02);
        wait_ev(1, 1000);
        check(8'(wd_overflow_flag), 8'h01);
        check(8'(n_rst), 8'h00);
        wait_ev(2, 2000);
        check(8'(reset_out.reset_source_code), 8'h0f);
    endtask
    task automatic t_sleep();
        wd_flag_clear = 1'b1;
        @(negedge sys_clk);
        wd_flag_clear = 1'b0;
        check(8'(wd_overflow_flag), 8'h00);
        n_wake = 0;
        sbc_mode = sbcwd_pkg::SBCWD_SBC_SLEEP;
        wait_ev(3, 2000);
        check(8'(n_wake), 8'h01);
        sbc_mode = sbcwd_pkg::SBCWD_SBC_STANDBY;
    endtask
    task automatic t_window();
        n_fail = 0;
        n_rst = 0;
        wr(`SBCWD_ADDR_CTRL, 8'h63);
        check(8'(n_fail), 8'h01);
        wr(`SBCWD_ADDR_CTRL, 8'h88);
        check(8'(wd_phase_status), 8'h01);
        wait_ev(0, 2000);
        check(8'(n_rst), 8'h00);
        sbc_mode = sbcwd_pkg::SBCWD_SBC_NORMAL;
        wr(`SBCWD_ADDR_CTRL, 8'h88);
        check(8'(n_rst), 8'h00);
        wr(`SBCWD_ADDR_CTRL, 8'h88);
        check(8'(n_rst), 8'h01);
        check(8'(reset_out.reset_source_code), 8'h0e);
        wait_ev(0, 2000);
        n_rst = 0;
        wr(`SBCWD_ADDR_CTRL, 8'h88);
        check(8'(n_rst), 8'h00);
        check(8'(wd_phase_status), 8'h01);
        wait_ev(2, 2000);
        check(8'(reset_out.reset_source_code), 8'h0f);
        n_rst = 0;
        wr(`SBCWD_ADDR_CTRL, 8'h48);
        check(8'(n_rst), 8'h01);
        check(8'(reset_out.reset_source_code), 8'h10);
        rdck(`SBCWD_ADDR_CTRL, 8'h88);
    endtask
    task automatic t_sdm();
        wr(`SBCWD_ADDR_CFG, 8'h04);
        check(8'(sw_dev_active), 8'h01);
        sbc_mode = sbcwd_pkg::SBCWD_SBC_RESET;
        repeat (10) @(negedge sys_clk);
        sbc_mode = sbcwd_pkg::SBCWD_SBC_NORMAL;
        rdck(`SBCWD_ADDR_CTRL, 8'h24);
        repeat (300) @(negedge sys_clk);
        check(8'(wd_phase_status), 8'h00);
        rdck(`SBCWD_ADDR_STAT, 8'h04);
        wr(`SBCWD_ADDR_CFG, 8'h00);
        repeat (20) @(negedge sys_clk);
        check(8'(wd_phase_status), 8'h01);
        sbc_mode = sbcwd_pkg::SBCWD_SBC_STANDBY;
        repeat (20) @(negedge sys_clk);
        check(8'(wd_phase_status), 8'h00);
        irq_out_n = 1'b0;
        repeat (20) @(negedge sys_clk);
        check(8'(wd_phase_status), 8'h01);
    endtask
    task automatic t_forced();
        sbc_mode = sbcwd_pkg::SBCWD_SBC_FORCED;
        repeat (10) @(negedge sys_clk);
        check(8'(wd_phase_status), 8'h00);
        check(8'(forced_norm_active), 8'h01);
        rdck(`SBCWD_ADDR_STAT, 8'h08);
        sbc_mode = sbcwd_pkg::SBCWD_SBC_OTHER;
        repeat (10) @(negedge sys_clk);
        check(8'(wd_phase_status), 8'h00);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        sbc_mode = sbcwd_pkg::SBCWD_SBC_NORMAL;
        irq_out_n = 1'b1;
        wd_flag_clear = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_reset();
        sbc_mode = sbcwd_pkg::SBCWD_SBC_STANDBY;
        t_cfg();
        t_timeout();
        t_sleep();
        t_window();
        t_sdm();
        t_forced();
        end_of_test();
    end
    // The full sequence needs about 110 us; the limit leaves a wide margin.
    initial begin
        #600000;
        n_mismatch++;
        end_of_test();
    end
endmodule
